/* File: clic_pkg.sv */
// Purpose: shared constants and types for the cascaded interrupt controller pair
// Assumes: 8-bit port data, 16-bit I/O addresses, one 100 MHz clock
// Notes:   master owns request inputs 0..7, slave owns 8..15
//
// How it works
// R1: resolver forwards only the single highest-priority request; level 0 ranks first until a rotation.
// R2: a rising request input sets its pending bit; several may set together.
// R3: processor interrupt rises only for unmasked requests outranking every in-service level, or not in service in special mask mode.
// R4: first acknowledge copies the winning pending bit to in-service and clears it.
// R5: second acknowledge delivers the 8-bit handler vector to the processor.
// R6: cascade lines pick master or slave at first acknowledge; only it answers.
// R7: slave interrupt output drives master request input 2.
// R8: init word one restarts init; words two, three (skipped in single mode), optional four follow.
// R9: operation words are accepted only once initialization has finished.
// R10: software writes 04h to master and 02h to slave as init word three.
// R11: master decodes 020h/021h, slave 0A0h/0A1h; even reads pending/in-service, odd mask.
// R12: even port takes init word one and op words two, three; odd takes rest.
// R13: in-service bit holds after acknowledge, blocking equal and lower levels only; in special mask mode it blocks just its own level.
// R14: software sends end-of-service to slave and master for cascaded interrupts.
// R15: non-specific end-of-service clears the highest-priority in-service bit.
// R16: specific end-of-service clears the in-service bit at the given level code.
// R17: in-service bits never clear without an explicit command; no automatic end.
// R18: rotate with non-specific end clears serviced level and makes it lowest.
// R19: rotate-in-automatic-end flag set by 100 code, cleared by 000 code.
// R20: set-priority command makes the given level lowest; next one becomes highest.
// R21: special mask mode blocks only masked levels and levels whose own in-service bit is set.
// R22: op word three enters or leaves special mask mode via change and value bits.
// R23: edge mode acknowledge clears pending; level mode pending follows the input.
// R24: trigger registers at 4D0h and 4D1h select edge or level per input.
// R25: inputs 0 and 2 stay edge; writing ffh to 4D0h reads back 0FAh.
// R26: bit 0 of init word one says whether init word four follows.
// R27: op word three read-select chooses pending or in-service for even reads.
package clic_pkg;

    localparam int IO_ADDR_W = 16;

    // port addresses
    localparam logic [15:0] MASTER_CMD_ADDR  = 16'h0020;
    localparam logic [15:0] MASTER_DATA_ADDR = 16'h0021;
    localparam logic [15:0] SLAVE_CMD_ADDR   = 16'h00a0;
    localparam logic [15:0] SLAVE_DATA_ADDR  = 16'h00a1;
    localparam logic [15:0] TRIG_LO_ADDR     = 16'h04d0;
    localparam logic [15:0] TRIG_HI_ADDR     = 16'h04d1;

    // field positions
    localparam int INIT1_FLAG_BIT   = 4;
    localparam int INIT1_NEED4_BIT  = 0;
    localparam int INIT1_SINGLE_BIT = 1;
    localparam int OP3_SEL_BIT      = 3;
    localparam int OP2_ROT_BIT      = 7;
    localparam int OP2_SEL_BIT      = 6;
    localparam int OP2_END_BIT      = 5;
    localparam int OP3_SMM_CHG_BIT  = 6;
    localparam int OP3_SMM_VAL_BIT  = 5;
    localparam int OP3_RD_CHG_BIT   = 1;
    localparam int OP3_RD_ISR_BIT   = 0;

    // values after reset and fixed codes
    localparam logic [7:0]  MASK_RESET       = 8'hff;
    localparam logic [2:0]  PRIO_LOW_RESET   = 3'h7;
    localparam logic [2:0]  SPURIOUS_LEVEL   = 3'h7;
    localparam logic [15:0] TRIG_WRITE_MASK  = 16'hfffa;
    localparam logic [15:0] TRIG_RESET       = 16'h0000;

    typedef enum logic [2:0] {
        ST_UNINIT,
        ST_W2,
        ST_W3,
        ST_W4,
        ST_READY
    } clic_init_type;

    typedef enum logic [2:0] {
        P_NONE,
        P_MCMD,
        P_MDATA,
        P_SCMD,
        P_SDATA,
        P_TLO,
        P_THI
    } clic_port_type;

    typedef struct packed {
        logic                   wr;
        logic                   rd;
        logic [IO_ADDR_W-1:0]   addr;
        logic [7:0]             wdata;
    } clic_io_req_type;

    typedef struct packed {
        logic [7:0]     pending_request_reg;
        logic [7:0]     in_service_reg;
        logic [7:0]     request_mask_reg;
        logic [7:0]     prev;
        logic [4:0]     vec_base;
        logic [7:0]     casc;
        logic           need_w4;
        logic           single;
        logic [2:0]     prio_low;
        logic           rot_auto;
        logic           special_mask_value;
        logic           read_isr;
        clic_init_type  step;
    } clic_ctrl_type;

    typedef struct packed {
        clic_ctrl_type [1:0] ctrl;
        logic [15:0]         trig;
        logic                ack_phase;
        logic                sel_slave;
        logic [7:0]          vec_hold;
        logic [7:0]          vector;
        logic                vvalid;
        logic [7:0]          rdata;
        logic                rvalid;
    } clic_state_type;

endpackage : clic_pkg

/* File: clic_prio_pick.sv */
// Purpose: rotating priority pick over a request vector
// Assumes: levels rank upward from the level after low_i
// Notes:   purely combinational
module clic_prio_pick
    import clic_pkg::*;
#(
    parameter int LEVELS = 8,
    parameter int LW     = $clog2(LEVELS)
) (
    // request side
    input  wire logic [LEVELS-1:0] req_i,
    input  wire logic [LW-1:0]     low_i,
    // result
    output logic                   found_o,
    output logic [LW-1:0]          level_o
);

    if (LEVELS < 2 || (1 << LW) != LEVELS) begin : g_check
        $error("clic_prio_pick: LEVELS must be a power of two");
    end

    // walk from lowest rank upward so the highest rank is written last
    always_comb begin
        logic [LW-1:0] lvl;
        lvl     = '0;
        found_o = 1'b0;
        level_o = '0;
        for (int i = LEVELS - 1; i >= 0; i--) begin
            lvl = low_i + LW'(1) + LW'(i);
            if (req_i[lvl]) begin // [R1]
                found_o = 1'b1;
                level_o = lvl;
            end
        end
    end

endmodule // clic_prio_pick

/* File: clic_top.sv */
// Purpose: master/slave interrupt controller pair behind I/O ports
// Assumes: one-cycle strobes for port access and each acknowledge pulse
// Notes:   automatic end-of-service is not offered; commands clear in-service
module clic_top
    import clic_pkg::*;
(
    // clock and reset
    input  wire logic            clk_i,
    input  wire logic            reset_i,
    // port access
    input  wire clic_io_req_type io_req_i,
    output logic [7:0]           io_rdata_o,
    output logic                 io_rvalid_o,
    // interrupt sources
    input  wire logic [15:0]     request_inputs_i,
    // processor side
    input  wire logic            acknowledge_pulse_i,
    output logic                 processor_irq_out_o,
    output logic [7:0]           vector_o,
    output logic                 vector_valid_o
);

    function automatic clic_port_type port_of(input logic [IO_ADDR_W-1:0] a);
        case (a)
            MASTER_CMD_ADDR:  port_of = P_MCMD;
            MASTER_DATA_ADDR: port_of = P_MDATA;
            SLAVE_CMD_ADDR:   port_of = P_SCMD;
            SLAVE_DATA_ADDR:  port_of = P_SDATA;
            TRIG_LO_ADDR:     port_of = P_TLO;
            TRIG_HI_ADDR:     port_of = P_THI;
            default:          port_of = P_NONE;
        endcase
    endfunction

    // rank 0 is the highest priority under the current rotation
    function automatic logic [2:0] rank(input logic [2:0] lvl, input logic [2:0] low);
        rank = lvl - low - 3'd1;
    endfunction

    function automatic logic [7:0] onehot(input logic [2:0] lvl);
        onehot = 8'h01 << lvl;
    endfunction

    clic_state_type      r;
    clic_state_type      n;
    clic_port_type       port;
    logic [1:0][7:0]     in_v;
    logic [1:0][7:0]     level_m;
    logic [1:0][7:0]     cand_req;
    logic [1:0]          cand_found;
    logic [1:0][2:0]     cand_lvl;
    logic [1:0]          isr_found;
    logic [1:0][2:0]     isr_lvl;
    logic [1:0]          irq;

    assign port       = port_of(io_req_i.addr);
    // slave output is the master's level 2 request
    assign in_v[0]    = {request_inputs_i[7:3], irq[1], request_inputs_i[1:0]}; // [R7]
    assign in_v[1]    = request_inputs_i[15:8];
    assign level_m[0] = r.trig[7:0]; // [R24]
    assign level_m[1] = r.trig[15:8];

    for (genvar c = 0; c < 2; c++) begin : g_unit
        // special mask mode drops in-service levels from the candidates and skips the rank gate
        assign cand_req[c] = r.ctrl[c].special_mask_value ? (r.ctrl[c].pending_request_reg & ~r.ctrl[c].request_mask_reg & ~r.ctrl[c].in_service_reg)
                                           : (r.ctrl[c].pending_request_reg & ~r.ctrl[c].request_mask_reg); // [R21]

        clic_prio_pick #(
            .LEVELS (8)
        ) u_req_pick (
            .req_i   (cand_req[c]),
            .low_i   (r.ctrl[c].prio_low),
            .found_o (cand_found[c]),
            .level_o (cand_lvl[c])
        );

        clic_prio_pick #(
            .LEVELS (8)
        ) u_isr_pick (
            .req_i   (r.ctrl[c].in_service_reg),
            .low_i   (r.ctrl[c].prio_low),
            .found_o (isr_found[c]),
            .level_o (isr_lvl[c])
        );

        // no output until initialization has finished
        assign irq[c] = (r.ctrl[c].step == ST_READY) && cand_found[c]
                        && (r.ctrl[c].special_mask_value || !isr_found[c]
                            || (rank(cand_lvl[c], r.ctrl[c].prio_low)
                                < rank(isr_lvl[c], r.ctrl[c].prio_low))); // [R3] [R13] [R9]
    end

    always_comb begin
        clic_ctrl_type   cur;
        clic_ctrl_type   nx;
        logic [7:0]      rise;
        logic [7:0]      isr_clr;
        logic [7:0]      d;
        logic [1:0][7:0] ack_set;
        logic            first;
        logic            second;
        logic            casc_sel;
        logic            even;
        logic            odd;
        logic [2:0]      lcode;
        cur      = '0;
        nx       = '0;
        rise     = '0;
        isr_clr  = '0;
        d        = io_req_i.wdata;
        ack_set  = '0;
        even     = 1'b0;
        odd      = 1'b0;
        lcode    = d[2:0];
        n        = r;
        n.vvalid = 1'b0;
        n.rvalid = 1'b0;

        // acknowledge pair
        first    = acknowledge_pulse_i && !r.ack_phase;
        second   = acknowledge_pulse_i && r.ack_phase;
        casc_sel = irq[0] && r.ctrl[0].casc[cand_lvl[0]]
                   && (r.ctrl[1].casc[2:0] == cand_lvl[0]); // [R6]
        if (first) begin
            n.ack_phase = 1'b1;
            n.sel_slave = casc_sel;
            if (irq[0]) begin
                ack_set[0] = onehot(cand_lvl[0]); // [R4]
            end
            if (casc_sel && irq[1]) begin
                ack_set[1] = onehot(cand_lvl[1]);
            end
            // an acknowledge with nothing pending answers the spurious level
            if (casc_sel) begin
                n.vec_hold = {r.ctrl[1].vec_base, irq[1] ? cand_lvl[1] : SPURIOUS_LEVEL};
            end else begin
                n.vec_hold = {r.ctrl[0].vec_base, irq[0] ? cand_lvl[0] : SPURIOUS_LEVEL};
            end
        end
        if (second) begin
            n.ack_phase = 1'b0;
            n.vector    = r.vec_hold; // [R5] [R6]
            n.vvalid    = 1'b1;
        end

        for (int c = 0; c < 2; c++) begin
            cur     = r.ctrl[c];
            nx      = cur;
            isr_clr = '0;
            rise    = in_v[c] & ~cur.prev;
            nx.prev = in_v[c];
            // set wins over acknowledge clear on the same cycle
            nx.pending_request_reg  = (in_v[c] & level_m[c])
                      | (((cur.pending_request_reg & ~ack_set[c]) | rise) & ~level_m[c]); // [R2] [R23]
            even    = io_req_i.wr && (port == (c == 0 ? P_MCMD : P_SCMD));
            odd     = io_req_i.wr && (port == (c == 0 ? P_MDATA : P_SDATA));
            if (even && d[INIT1_FLAG_BIT]) begin
                nx.in_service_reg      = '0; // [R8]
                nx.request_mask_reg      = '0;
                nx.prio_low = PRIO_LOW_RESET;
                nx.rot_auto = 1'b0;
                nx.special_mask_value      = 1'b0;
                nx.read_isr = 1'b0; // [R27]
                nx.need_w4  = d[INIT1_NEED4_BIT]; // [R26]
                nx.single   = d[INIT1_SINGLE_BIT];
                nx.step     = ST_W2;
            end else begin
                if (even && cur.step == ST_READY) begin // [R9] [R12]
                    if (d[OP3_SEL_BIT]) begin
                        if (d[OP3_RD_CHG_BIT]) begin
                            nx.read_isr = d[OP3_RD_ISR_BIT]; // [R27]
                        end
                        if (d[OP3_SMM_CHG_BIT]) begin
                            nx.special_mask_value = d[OP3_SMM_VAL_BIT]; // [R22]
                        end
                    end else begin
                        case ({d[OP2_ROT_BIT], d[OP2_SEL_BIT], d[OP2_END_BIT]})
                            3'b001: begin
                                isr_clr = isr_found[c] ? onehot(isr_lvl[c]) : 8'h00; // [R15]
                            end
                            3'b101: begin
                                isr_clr = isr_found[c] ? onehot(isr_lvl[c]) : 8'h00; // [R18]
                                if (isr_found[c]) begin
                                    nx.prio_low = isr_lvl[c];
                                end
                            end
                            3'b011: begin
                                isr_clr = onehot(lcode); // [R16]
                            end
                            3'b111: begin
                                isr_clr     = onehot(lcode);
                                nx.prio_low = lcode;
                            end
                            3'b100: nx.rot_auto = 1'b1; // [R19]
                            3'b000: nx.rot_auto = 1'b0;
                            3'b110: nx.prio_low = lcode; // [R20]
                            default: ;
                        endcase
                    end
                end
                if (odd) begin
                    case (cur.step)
                        ST_W2: begin
                            nx.vec_base = d[7:3];
                            nx.step     = cur.single ? (cur.need_w4 ? ST_W4 : ST_READY) : ST_W3; // [R8]
                        end
                        ST_W3: begin
                            nx.casc = d; // [R10]
                            nx.step = cur.need_w4 ? ST_W4 : ST_READY; // [R26]
                        end
                        ST_W4:    nx.step = ST_READY;
                        ST_READY: nx.request_mask_reg  = d; // [R12]
                        default: ;
                    endcase
                end
                // only commands clear in-service; acknowledge set wins
                nx.in_service_reg = (cur.in_service_reg & ~isr_clr) | ack_set[c]; // [R17] [R13]
            end
            n.ctrl[c] = nx;
        end

        // trigger registers keep inputs 0 and 2 in edge mode
        if (io_req_i.wr && port == P_TLO) begin
            n.trig[7:0] = d & TRIG_WRITE_MASK[7:0]; // [R24] [R25]
        end
        if (io_req_i.wr && port == P_THI) begin
            n.trig[15:8] = d & TRIG_WRITE_MASK[15:8];
        end

        // reads answer one cycle later; unmapped addresses do not answer
        if (io_req_i.rd) begin
            n.rvalid = (port != P_NONE);
            case (port)
                P_MCMD:  n.rdata = r.ctrl[0].read_isr ? r.ctrl[0].in_service_reg : r.ctrl[0].pending_request_reg; // [R11]
                P_MDATA: n.rdata = r.ctrl[0].request_mask_reg;
                P_SCMD:  n.rdata = r.ctrl[1].read_isr ? r.ctrl[1].in_service_reg : r.ctrl[1].pending_request_reg;
                P_SDATA: n.rdata = r.ctrl[1].request_mask_reg;
                P_TLO:   n.rdata = r.trig[7:0];
                P_THI:   n.rdata = r.trig[15:8];
                default: n.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            r <= '0;
            for (int c = 0; c < 2; c++) begin
                r.ctrl[c].request_mask_reg      <= MASK_RESET;
                r.ctrl[c].prio_low <= PRIO_LOW_RESET;
                r.ctrl[c].step     <= ST_UNINIT;
            end
            r.trig <= TRIG_RESET;
        end else begin
            r <= n;
        end
    end

    assign io_rdata_o          = r.rdata;
    assign io_rvalid_o         = r.rvalid;
    assign vector_o            = r.vector;
    assign vector_valid_o      = r.vvalid;
    assign processor_irq_out_o = irq[0];

    // checks
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (reset_i);

    sequence s_first_ack;
        acknowledge_pulse_i && !r.ack_phase;
    endsequence

    sequence s_second_ack;
        acknowledge_pulse_i && r.ack_phase;
    endsequence

    sequence s_master_cmd(logic [7:0] v);
        io_req_i.wr && (port == P_MCMD) && (io_req_i.wdata == v) && (r.ctrl[0].step == ST_READY);
    endsequence

    a_vector_delivery: assert property ( // [R5]
        s_first_ack ##1 !acknowledge_pulse_i ##1 s_second_ack
        |=> vector_valid_o && (vector_o == $past(r.vec_hold)) ##1 !vector_valid_o
    ) else $error("vector not delivered after second acknowledge");

    a_ack_sets_isr: assert property ( // [R4]
        (s_first_ack and (irq[0] && !(io_req_i.wr && port == P_MCMD)))
        |=> r.ctrl[0].in_service_reg[$past(cand_lvl[0])]
            && (!r.ctrl[0].pending_request_reg[$past(cand_lvl[0])] || r.trig[$past(cand_lvl[0])]
                || (r.ctrl[0].prev[$past(cand_lvl[0])] && !$past(r.ctrl[0].prev[cand_lvl[0]])))
    ) else $error("acknowledge did not move pending to in-service");

    a_irq_gating: assert property ( // [R3]
        processor_irq_out_o |-> ((r.ctrl[0].pending_request_reg & ~r.ctrl[0].request_mask_reg) != 8'h00)
                                && (r.ctrl[0].step == ST_READY)
    ) else $error("interrupt raised without unmasked pending request");

    a_no_auto_clear: assert property ( // [R17]
        !(io_req_i.wr && port == P_MCMD) |=> (($past(r.ctrl[0].in_service_reg) & ~r.ctrl[0].in_service_reg) == 8'h00)
    ) else $error("in-service bit cleared without command");

    a_init_restart: assert property ( // [R8]
        (io_req_i.wr && port == P_SCMD && io_req_i.wdata[INIT1_FLAG_BIT])
        |=> (r.ctrl[1].step == ST_W2) && (r.ctrl[1].in_service_reg == 8'h00) && (r.ctrl[1].request_mask_reg == 8'h00)
    ) else $error("init word one did not restart initialization");

    a_op_after_init: assert property ( // [R9]
        (io_req_i.wr && port == P_MDATA && r.ctrl[0].step == ST_UNINIT)
        |=> r.ctrl[0].request_mask_reg == $past(r.ctrl[0].request_mask_reg)
    ) else $error("mask written before initialization");

    a_edge_forced: assert property ( // [R25]
        (r.trig & ~TRIG_WRITE_MASK) == 16'h0000
    ) else $error("input 0 or 2 left edge mode");

    a_level_follow: assert property ( // [R23]
        (r.trig != 16'h0000) |=> (((r.ctrl[0].pending_request_reg ^ $past(in_v[0])) & $past(level_m[0])) == 8'h00)
                                 && (((r.ctrl[1].pending_request_reg ^ $past(in_v[1])) & $past(level_m[1])) == 8'h00)
    ) else $error("level-mode pending bit does not follow input");

    a_cascade_select: assert property ( // [R6]
        (s_first_ack and (irq[0] && cand_lvl[0] == 3'd2 && r.ctrl[0].casc[2]
                          && r.ctrl[1].casc[2:0] == 3'd2)) |=> r.sel_slave
    ) else $error("slave not selected for cascade level");

    a_nonspec_end: assert property ( // [R15]
        (s_master_cmd(8'h20) and (isr_found[0] && !acknowledge_pulse_i))
        |=> !r.ctrl[0].in_service_reg[$past(isr_lvl[0])]
    ) else $error("non-specific end left highest in-service bit set");

    a_smm_enter: assert property ( // [R22]
        s_master_cmd(8'h68) |=> r.ctrl[0].special_mask_value ##1 r.ctrl[0].special_mask_value || $past(io_req_i.wr)
    ) else $error("special mask mode not entered");

    a_rot_auto_flag: assert property ( // [R19]
        (s_master_cmd(8'h80) or s_master_cmd(8'h00)) |=> r.ctrl[0].rot_auto == $past(io_req_i.wdata[7])
    ) else $error("rotate-in-automatic flag not updated");

endmodule // clic_top

/* File: clic_cpu_model.sv */
// Purpose: processor model issuing port accesses and acknowledge pulse pairs
// Assumes: one-cycle strobes launched just after a rising edge
// Notes:   released address and data show the inverse of the last value
module clic_cpu_model
    import clic_pkg::*;
(
    // clock
    input  wire logic       clk_i,
    // answers from the controller pair
    input  wire logic [7:0] io_rdata_i,
    input  wire logic       io_rvalid_i,
    input  wire logic [7:0] vector_i,
    input  wire logic       vector_valid_i,
    // requests to the controller pair
    output clic_io_req_type io_req_o,
    output logic            ack_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // master words then slave words, cascade on level 2
    localparam logic [23:0] INIT_SEQ [8] = '{24'h002011, 24'h002108, 24'h002104, 24'h002101,
        24'h00a011, 24'h00a170, 24'h00a102, 24'h00a101};
    initial begin
        io_req_o = '0;
        ack_o = 1'b0;
    end
    task automatic io_acc(input logic w, input logic [15:0] a, input logic [7:0] v,
                          output logic [8:0] r);
        @(posedge clk_i);
        io_req_o <= '{wr: w, rd: !w, addr: a, wdata: v};
        @(posedge clk_i);
        io_req_o <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~v};
        @(negedge clk_i);
        r = {io_rvalid_i, io_rdata_i};
    endtask
    // whole init of both before any operation word
    task automatic init_pair();
        logic [8:0] r;
        foreach (INIT_SEQ[i]) io_acc(1'b1, INIT_SEQ[i][23:8], INIT_SEQ[i][7:0], r);
    endtask
    // cascaded level: slave first, then master
    task automatic eoi_pair();
        logic [8:0] r;
        io_acc(1'b1, SLAVE_CMD_ADDR, 8'h20, r);
        io_acc(1'b1, MASTER_CMD_ADDR, 8'h20, r);
    endtask
    task automatic ack_pair(output logic [8:0] r);
        repeat (2) begin
            @(posedge clk_i);
            ack_o <= 1'b1;
            @(posedge clk_i);
            ack_o <= 1'b0;
        end
        @(negedge clk_i);
        r = {vector_valid_i, vector_i};
    endtask
endmodule // clic_cpu_model

/* File: cascaded_legacy_interrupt_controller_bench.sv */
// Purpose: self-checking bench for the cascaded controller pair
// Assumes: cpu model owns port and acknowledge strobes
// Notes:   sources start in edge mode; one scenario uses level mode
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin failures++; \
    $display("BAD %0t got %h want %h", $time, (a), (e)); end end
module cascaded_legacy_interrupt_controller_bench
    import clic_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [15:0] MC = MASTER_CMD_ADDR;
    localparam logic [15:0] MD = MASTER_DATA_ADDR;
    logic            clk_i, reset_i, ack, irq, rvalid, vvalid;
    logic [15:0]     req_r;
    logic [7:0]      rdata, vec, p, m;
    logic [8:0]      r;
    clic_io_req_type io_req;
    int              failures, samples_checked;
    clic_top clic_top_i (.clk_i(clk_i), .reset_i(reset_i), .io_req_i(io_req), .io_rdata_o(rdata),
        .io_rvalid_o(rvalid), .request_inputs_i(req_r), .acknowledge_pulse_i(ack),
        .processor_irq_out_o(irq), .vector_o(vec), .vector_valid_o(vvalid));
    clic_cpu_model clic_cpu_model_i (.clk_i(clk_i), .io_rdata_i(rdata), .io_rvalid_i(rvalid),
        .vector_i(vec), .vector_valid_i(vvalid), .io_req_o(io_req), .ack_o(ack));
    function automatic logic [2:0] low_lvl(input logic [7:0] v);
        low_lvl = 3'h0;
        for (int i = 7; i >= 0; i--) if (v[i]) low_lvl = 3'(i);
    endfunction
    task automatic wr(input logic [15:0] a, input logic [7:0] v);
        clic_cpu_model_i.io_acc(1'b1, a, v, r);
    endtask
    task automatic rdx(input logic [15:0] a, input logic [8:0] e);
        clic_cpu_model_i.io_acc(1'b0, a, 8'h00, r);
        `CHK(r, e)
    endtask
    task automatic ackx(input logic [7:0] e);
        clic_cpu_model_i.ack_pair(r);
        `CHK(r, {1'b1, e})
    endtask
    task automatic irqx(input logic e);
        @(negedge clk_i);
        `CHK(irq, e)
    endtask
    task automatic src(input logic [15:0] s, input logic on);
        @(posedge clk_i);
        req_r <= on ? (req_r | s) : (req_r & ~s);
        repeat (2) @(posedge clk_i);
    endtask
    task automatic complete_run();
        $display("failures=%0d samples_checked=%0d", failures, samples_checked);
        if (failures == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    // whole run is a few hundred cycles
    initial begin
        #100us;
        failures++;
        complete_run();
    end
    initial begin
        failures = 0;
        samples_checked = 0;
        req_r = '0;
        reset_i = 1'b1;
        void'($urandom(4014));
        repeat (20) @(posedge clk_i);
        reset_i <= 1'b0;
        wr(MD, 8'h00);
        rdx(MD, 9'h1ff);
        clic_cpu_model_i.io_acc(1'b0, 16'h0022, 8'h00, r);
        `CHK(r[8], 1'b0)
        clic_cpu_model_i.init_pair();
        rdx(SLAVE_DATA_ADDR, 9'h100);
        m = 8'($urandom);
        wr(MD, m);
        rdx(MD, {1'b1, m});
        src(16'h0010, 1'b1);
        irqx(!m[4]);
        wr(MD, 8'h00);
        ackx(8'h0c);
        wr(MC, 8'h20);
        src(16'h0010, 1'b0);
        // random bursts: acknowledge drains them strictly by level
        repeat (6) begin
            p = 8'($urandom) & 8'hfb;
            if (p == 8'h00) p = 8'h80;
            m = p;
            src({8'h00, p}, 1'b1);
            while (p != 8'h00) begin
                irqx(1'b1);
                ackx({5'h01, low_lvl(p)});
                irqx(1'b0);
                p[low_lvl(p)] = 1'b0;
                wr(MC, 8'h20);
            end
            irqx(1'b0);
            src({8'h00, m}, 1'b0);
        end
        src(16'h0008, 1'b1);
        ackx(8'h0b);
        src(16'h0020, 1'b1);
        irqx(1'b0);
        src(16'h0002, 1'b1);
        irqx(1'b1);
        ackx(8'h09);
        wr(MC, 8'h63);
        wr(MC, 8'h0b);
        rdx(MC, 9'h102);
        wr(MC, 8'h0a);
        wr(MC, 8'h20);
        irqx(1'b1);
        ackx(8'h0d);
        wr(MC, 8'h20);
        src(16'h002a, 1'b0);
        src(16'h1000, 1'b1);
        irqx(1'b1);
        ackx(8'h74);
        wr(MC, 8'h0b);
        rdx(MC, 9'h104);
        clic_cpu_model_i.eoi_pair();
        rdx(MC, 9'h100);
        wr(MC, 8'h0a);
        src(16'h1000, 1'b0);
        wr(MC, 8'hc4);
        src(16'h0048, 1'b1);
        ackx(8'h0e);
        wr(MC, 8'h20);
        ackx(8'h0b);
        wr(MC, 8'h20);
        wr(MC, 8'hc7);
        src(16'h0048, 1'b0);
        src(16'h0001, 1'b1);
        ackx(8'h08);
        wr(MC, 8'ha0);
        src(16'h0001, 1'b0);
        src(16'h0003, 1'b1);
        ackx(8'h09);
        wr(MC, 8'h20);
        ackx(8'h08);
        wr(MC, 8'h20);
        wr(MC, 8'hc7);
        wr(MC, 8'h80);
        wr(MC, 8'h00);
        src(16'h0003, 1'b0);
        src(16'h0002, 1'b1);
        ackx(8'h09);
        wr(MC, 8'h68);
        wr(MD, 8'h20);
        src(16'h0028, 1'b1);
        irqx(1'b1);
        ackx(8'h0b);
        wr(MC, 8'h48);
        wr(MD, 8'h00);
        irqx(1'b0);
        wr(MC, 8'h20);
        wr(MC, 8'h20);
        ackx(8'h0d);
        wr(MC, 8'h20);
        src(16'h002a, 1'b0);
        wr(TRIG_LO_ADDR, 8'hff);
        rdx(TRIG_LO_ADDR, 9'h1fa);
        src(16'h0008, 1'b1);
        ackx(8'h0b);
        wr(MC, 8'h20);
        irqx(1'b1);
        src(16'h0008, 1'b0);
        irqx(1'b0);
        complete_run();
    end
endmodule // cascaded_legacy_interrupt_controller_bench
